// ==== include/touch_irq_pkg.sv ====
// constants for the touch sensor interrupt unit: register map, fields, resets
// assumes a 32-bit AHB-Lite register bus with one register per aligned word
package touch_irq_pkg;

	// number of conversion stages, stage n maps to bit n
	localparam int STAGES = 12;
	localparam int REG_W = 16;

	// register indices; byte address is four times the index
	localparam logic [29:0] IDX_TOUCH_LOW_EN = 30'h005;
	localparam logic [29:0] IDX_TOUCH_HIGH_EN = 30'h006;
	localparam logic [29:0] IDX_CONV_DONE_EN = 30'h007;
	localparam logic [29:0] IDX_TOUCH_LOW_FLAGS = 30'h008;
	localparam logic [29:0] IDX_TOUCH_HIGH_FLAGS = 30'h009;
	localparam logic [29:0] IDX_CONV_DONE_FLAGS = 30'h00A;

	// field positions
	localparam int GPIO_EN_BIT = 12;
	localparam int GPIO_FLAG_BIT = 12;
	localparam int GPIO_SETUP_LSB = 12;
	localparam int GPIO_TRIG_LSB = 14;

	// reset values
	localparam logic [15:0] ENABLE_RESET = 16'h0000;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;

	// gpio pin configuration, only the input setting raises requests
	localparam logic [1:0] GPIO_SETUP_INPUT = 2'h1;

	// gpio trigger selection
	typedef enum logic [1:0] {
		GPIO_LOW_LEVEL = 2'h0,
		GPIO_RISE_EDGE = 2'h1,
		GPIO_FALL_EDGE = 2'h2,
		GPIO_HIGH_LEVEL = 2'h3
	} gpio_trig_type;

endpackage : touch_irq_pkg

// ==== core/gpio_trigger.sv ====
// gpio trigger detector: level or edge event from the general-purpose input
// assumes gpio_i is already synchronous to clk_i
`timescale 1ns/1ps
module gpio_trigger (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic gpio_i,
	input wire logic active_i,
	input wire logic [1:0] mode_i,
	output logic hit_o
);

	logic prev;
	logic rise;
	logic fall;

	// previous pin level for edge detection
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prev <= 1'b0;
		end else begin
			prev <= gpio_i;
		end
	end

	assign rise = gpio_i & ~prev;
	assign fall = ~gpio_i & prev;

	// level modes hold while the level lasts, edge modes give one cycle
	always_comb begin
		case (touch_irq_pkg::gpio_trig_type'(mode_i))
			touch_irq_pkg::GPIO_LOW_LEVEL: hit_o = active_i & ~gpio_i;
			touch_irq_pkg::GPIO_RISE_EDGE: hit_o = active_i & rise;
			touch_irq_pkg::GPIO_FALL_EDGE: hit_o = active_i & fall;
			touch_irq_pkg::GPIO_HIGH_LEVEL: hit_o = active_i & gpio_i;
			default: hit_o = 1'b0;
		endcase
	end

endmodule : gpio_trigger

// ==== core/touch_irq_unit.sv ====
// touch sensor interrupt unit: merges conversion, touch and gpio events
// onto one open-drain request, registers over an AHB-Lite slave
// assumes one clock, event inputs synchronous to clk_i, zero-wait bus
`timescale 1ns/1ps

module touch_irq_unit #(
	parameter int STAGES = touch_irq_pkg::STAGES
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [STAGES-1:0] conv_done_i,
	input wire logic [STAGES-1:0] touch_low_i,
	input wire logic [STAGES-1:0] touch_high_i,
	input wire logic gpio_i,
	output logic irq_o,
	output logic irq_oe_o
);

	logic [15:0] touch_low_en;
	logic [15:0] touch_high_en;
	logic [15:0] conv_en;
	logic [STAGES-1:0] conv_flags;
	logic gpio_flag;
	logic [STAGES-1:0] touch_low_q;
	logic [STAGES-1:0] touch_high_q;
	logic touch_pend;
	logic wr_pend;
	logic [29:0] wr_idx;
	logic [31:0] next_rdata;
	logic [STAGES-1:0] next_conv_flags;
	logic next_gpio_flag;
	logic next_touch_pend;
	logic next_pending;
	logic addr_phase;
	logic [29:0] acc_idx;
	logic rd_access;
	logic rd_conv;
	logic rd_touch;
	logic [STAGES-1:0] conv_set;
	logic [STAGES-1:0] touch_low_cur;
	logic [STAGES-1:0] touch_high_cur;
	logic touch_change;
	logic gpio_hit;
	logic gpio_active;
	logic any_event;

	// zero-extend a stage vector into a register word
	function automatic logic [31:0] stage_word(input logic [STAGES-1:0] v);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[STAGES-1:0] = v;
		return w;
	endfunction : stage_word

	// bus decode; only word transfers exist, so hsize is not checked
	assign addr_phase = hsel_i & htrans_i[1] & hready_i;
	assign acc_idx = haddr_i[31:2];
	assign rd_access = addr_phase & ~hwrite_i;
	assign rd_conv = rd_access & (acc_idx == touch_irq_pkg::IDX_CONV_DONE_FLAGS);
	assign rd_touch = rd_access & ((acc_idx == touch_irq_pkg::IDX_TOUCH_LOW_FLAGS) |
		(acc_idx == touch_irq_pkg::IDX_TOUCH_HIGH_FLAGS));
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	// read mux, sampled at the address phase so data shows the pre-clear value
	always_comb begin
		case (acc_idx)
			touch_irq_pkg::IDX_TOUCH_LOW_EN: next_rdata = {16'h0000, touch_low_en};
			touch_irq_pkg::IDX_TOUCH_HIGH_EN: next_rdata = {16'h0000, touch_high_en};
			touch_irq_pkg::IDX_CONV_DONE_EN: next_rdata = {16'h0000, conv_en};
			touch_irq_pkg::IDX_TOUCH_LOW_FLAGS: next_rdata = stage_word(touch_low_i);
			touch_irq_pkg::IDX_TOUCH_HIGH_FLAGS: next_rdata = stage_word(touch_high_i);
			touch_irq_pkg::IDX_CONV_DONE_FLAGS: begin
				next_rdata = stage_word(conv_flags);
				next_rdata[touch_irq_pkg::GPIO_FLAG_BIT] = gpio_flag;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// read data register, updated only when a read is accepted
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (rd_access) begin
			hrdata_o <= next_rdata;
		end
	end

	// write address held for the data phase
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_pend <= 1'b0;
			wr_idx <= 30'h0;
		end else if (hready_i) begin
			wr_pend <= addr_phase & hwrite_i;
			wr_idx <= acc_idx;
		end
	end

	// enable registers; writes to status or unmapped words are dropped
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			touch_low_en <= touch_irq_pkg::ENABLE_RESET;
			touch_high_en <= touch_irq_pkg::ENABLE_RESET;
			conv_en <= touch_irq_pkg::ENABLE_RESET;
		end else if (wr_pend) begin
			if (wr_idx == touch_irq_pkg::IDX_TOUCH_LOW_EN)
				touch_low_en <= hwdata_i[15:0];
			if (wr_idx == touch_irq_pkg::IDX_TOUCH_HIGH_EN)
				touch_high_en <= hwdata_i[15:0];
			if (wr_idx == touch_irq_pkg::IDX_CONV_DONE_EN)
				conv_en <= hwdata_i[15:0];
		end
	end

	// completion events of enabled stages; bit n belongs to stage n
	assign conv_set = conv_done_i & conv_en[STAGES-1:0];
	// set beats clear, so a completion during the read stays visible
	assign next_conv_flags = (conv_flags & ~{STAGES{rd_conv}}) | conv_set;

	// gpio raises requests only when configured as an input
	assign gpio_active = (touch_low_en[touch_irq_pkg::GPIO_SETUP_LSB +: 2] ==
		touch_irq_pkg::GPIO_SETUP_INPUT) & conv_en[touch_irq_pkg::GPIO_EN_BIT];

	gpio_trigger u_gpio_trigger (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.gpio_i(gpio_i),
		.active_i(gpio_active),
		.mode_i(touch_low_en[touch_irq_pkg::GPIO_TRIG_LSB +: 2]),
		.hit_o(gpio_hit)
	);

	// a held level re-sets the flag each cycle, so a read cannot drop it
	assign next_gpio_flag = (gpio_flag & ~rd_conv) | gpio_hit;

	// touch activations masked by their enables, compared with last cycle
	assign touch_low_cur = touch_low_i & touch_low_en[STAGES-1:0];
	assign touch_high_cur = touch_high_i & touch_high_en[STAGES-1:0];
	// contact, count change and release all differ from the last state
	assign touch_change = (touch_low_cur != touch_low_q) |
		(touch_high_cur != touch_high_q);
	assign next_touch_pend = (touch_pend & ~rd_touch) | touch_change;

	// one request from all three sources
	assign next_pending = (|next_conv_flags) | next_gpio_flag | next_touch_pend;
	// any source setting a flag this cycle, for checking the request's cause
	assign any_event = (|conv_set) | gpio_hit | touch_change;

	// status and request state
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			conv_flags <= touch_irq_pkg::FLAGS_RESET[STAGES-1:0];
			gpio_flag <= 1'b0;
			touch_pend <= 1'b0;
			touch_low_q <= '0;
			touch_high_q <= '0;
			irq_oe_o <= 1'b0;
		end else begin
			conv_flags <= next_conv_flags;
			gpio_flag <= next_gpio_flag;
			touch_pend <= next_touch_pend;
			touch_low_q <= touch_low_cur;
			touch_high_q <= touch_high_cur;
			irq_oe_o <= next_pending;
		end
	end

	// the pin is only ever pulled low, never driven high
	assign irq_o = 1'b0;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	a_conv_raises_irq: assert property ((|(conv_done_i & conv_en[STAGES-1:0])) |=>
		irq_oe_o && (conv_flags != '0))
		else $error("enabled completion did not pull the request low");

	a_irq_tracks_flags: assert property (irq_oe_o ==
		((|conv_flags) || gpio_flag || touch_pend))
		else $error("request line disagrees with pending flags");

	a_irq_pin_low: assert property ((irq_o == 1'b0) &&
		(!$rose(irq_oe_o) || $past(any_event)))
		else $error("request pin driven high or raised with no event");

	a_conv_read_clear: assert property ((rd_conv && (conv_done_i & conv_en[STAGES-1:0]) == '0)
		|=> conv_flags == '0)
		else $error("completion flags not cleared by status read");

	a_touch_hold: assert property ((touch_pend && !rd_touch) |=> touch_pend)
		else $error("touch request released without a status read");

	a_touch_change: assert property (touch_change |=> touch_pend ##0 irq_oe_o)
		else $error("touch status change did not raise the request");

	a_touch_live_read: assert property ((rd_access && acc_idx ==
		touch_irq_pkg::IDX_TOUCH_LOW_FLAGS) |=> hrdata_o[STAGES-1:0] == $past(touch_low_i))
		else $error("touch status read is not the live activation state");

	a_gpio_level_hold: assert property ((gpio_active && gpio_i &&
		touch_low_en[touch_irq_pkg::GPIO_TRIG_LSB +: 2] == 2'h3) |=> gpio_flag && irq_oe_o)
		else $error("high-level gpio trigger did not hold the request");

	a_conv_en_write: assert property ((wr_pend && wr_idx == touch_irq_pkg::IDX_CONV_DONE_EN)
		|=> conv_en == $past(hwdata_i[15:0]))
		else $error("completion enable write lost");

	a_read_release: assert property ((rd_conv && !rd_touch && !touch_pend && !gpio_hit &&
		(conv_done_i & conv_en[STAGES-1:0]) == '0 && !touch_change) |=> !irq_oe_o)
		else $error("request not released after status read");

endmodule : touch_irq_unit

// ==== verification/host_irq_line.sv ====
// host side of the open-drain request line, with its pull-up
// assumes irq_oe_i high means the device pulls the line low
`timescale 1ns/1ps
module host_irq_line (
	input wire logic irq_i,
	input wire logic irq_oe_i,
	output logic line_n_o
);
	// a released line floats to the pull-up level, never the last value
	assign line_n_o = irq_oe_i ? irq_i : 1'h1;
endmodule : host_irq_line

// ==== verification/test_touch_sensor_interrupt_unit.sv ====
// self-checking bench for the touch interrupt unit, host as bus master
// assumes at most 63 wait states per phase; every wait is bounded and counted on timeout
`timescale 1ns/1ps
module test_touch_sensor_interrupt_unit;
	logic clk_i = 1'h0;
	logic nrst_i = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] dummy;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic hready;
	logic hresp;
	logic [11:0] conv = 12'h0;
	logic [11:0] touch_low = 12'h0;
	logic [11:0] touch_high = 12'h0;
	logic gpio = 1'h0;
	logic irq;
	logic irq_oe;
	logic irq_n;
	int mismatches = 0;
	int checked = 0;

	always #2 clk_i = ~clk_i;

	touch_irq_unit touch_irq_unit_i (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(1'h1),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
		.hresp_o(hresp), .conv_done_i(conv), .touch_low_i(touch_low), .touch_high_i(touch_high),
		.gpio_i(gpio), .irq_o(irq), .irq_oe_o(irq_oe));
	host_irq_line host_irq_line_i (.irq_i(irq), .irq_oe_i(irq_oe), .line_n_o(irq_n));

	task automatic stop_test();
		$display("mismatches=%0d checked=%0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	// bounded wait for hready at a rising edge
	task automatic step();
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hready !== 1'h1 && n < 64);
		if (hready !== 1'h1) begin
			mismatches++;
			stop_test();
		end
	endtask : step

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk_i);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		step();
		htrans <= 2'h0;
		hwdata <= wd;
		step();
		rd = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'h1, a, d, dummy);
	endtask : wr

	task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'h0, a, 32'h0, r);
		check(r, exp);
	endtask : rdc

	// line level checked just after the edge has settled
	task automatic line_is(input logic v);
		#1;
		check({31'h0, irq_n}, {31'h0, v});
	endtask : line_is

	task automatic reg_case();
		for (int i = 0; i < 6; i++) rdc(32'h14 + 32'(4 * i), 32'h0);
		rdc(32'h0, 32'h0);
		for (int i = 0; i < 3; i++) begin
			wr(32'h14 + 32'(4 * i), 32'hFFFF_0ABC);
			rdc(32'h14 + 32'(4 * i), 32'h0000_0ABC);
			wr(32'h14 + 32'(4 * i), 32'h0);
		end
		wr(32'h20, 32'hFFFF);
		rdc(32'h20, 32'h0);
		line_is(1'h1);
	endtask : reg_case

	task automatic pulse(input logic [11:0] v);
		@(posedge clk_i);
		conv <= v;
		@(posedge clk_i);
		conv <= 12'h0;
	endtask : pulse

	// only the last stage of the sequence is enabled, as the host should
	task automatic conv_case();
		wr(32'h1C, 32'h0800);
		pulse(12'h008);
		line_is(1'h1);
		pulse(12'h800);
		line_is(1'h0);
		rdc(32'h28, 32'h0800);
		line_is(1'h1);
		// completion arriving with the status read: the set must survive the clear
		@(posedge clk_i);
		htrans <= 2'h2;
		haddr <= 32'h28;
		hwrite <= 1'h0;
		conv <= 12'h800;
		step();
		htrans <= 2'h0;
		conv <= 12'h0;
		step();
		check(hrdata, 32'h0);
		line_is(1'h0);
		rdc(32'h28, 32'h0800);
		line_is(1'h1);
		wr(32'h1C, 32'h0);
	endtask : conv_case

	task automatic touch_case(input logic [31:0] en_a, input logic [31:0] fl_a, input int b,
		input logic hi);
		logic [11:0] v;
		v = 12'h001 << b;
		wr(en_a, 32'(v));
		@(posedge clk_i);
		if (hi) touch_high <= v;
		else touch_low <= v;
		@(posedge clk_i);
		line_is(1'h0);
		rdc(fl_a, 32'(v));
		line_is(1'h1);
		@(posedge clk_i);
		touch_high <= 12'h0;
		touch_low <= 12'h0;
		@(posedge clk_i);
		line_is(1'h0);
		rdc(fl_a, 32'h0);
		line_is(1'h1);
		wr(en_a, 32'h0);
	endtask : touch_case

	// idle level never triggers the selected mode
	task automatic gpio_case(input logic [1:0] m);
		logic idle;
		idle = (m == 2'h0) || (m == 2'h2);
		@(posedge clk_i);
		gpio <= idle;
		wr(32'h14, {16'h0, m, 14'h1000});
		bus(1'h0, 32'h28, 32'h0, dummy);
		line_is(1'h1);
		@(posedge clk_i);
		gpio <= ~idle;
		repeat (3) @(posedge clk_i);
		line_is(1'h0);
		rdc(32'h28, 32'h1000);
		line_is(m[0] ^ m[1]);
		@(posedge clk_i);
		gpio <= idle;
		repeat (3) @(posedge clk_i);
		bus(1'h0, 32'h28, 32'h0, dummy);
		line_is(1'h1);
	endtask : gpio_case

	// gpio stays quiet unless set up as an input and enabled
	task automatic gpio_off_case();
		wr(32'h14, 32'h0);
		repeat (3) @(posedge clk_i);
		line_is(1'h1);
		wr(32'h1C, 32'h0);
		wr(32'h14, 32'h1000);
		repeat (3) @(posedge clk_i);
		line_is(1'h1);
	endtask : gpio_off_case

	initial begin
		repeat (8) @(posedge clk_i);
		nrst_i <= 1'h1;
		reg_case();
		conv_case();
		touch_case(32'h14, 32'h20, 0, 1'h0);
		touch_case(32'h18, 32'h24, 11, 1'h1);
		wr(32'h1C, 32'h1000);
		for (int m = 0; m < 4; m++) gpio_case(2'(m));
		gpio_off_case();
		stop_test();
	end
endmodule : test_touch_sensor_interrupt_unit
